// ### dacu_pkg.sv
// Purpose: shared constants and types of the analog output update control
// Assumes: APB slave with 32-bit data, byte addresses on an 8-bit paddr
// Notes:   control and status travel as packed structs

package dacu_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CHA_VALUE  = 8'h00;
  localparam logic [7:0] ADDR_CHB_VALUE  = 8'h04;
  localparam logic [7:0] ADDR_CONTROL    = 8'h08;
  localparam logic [7:0] ADDR_UPD_STROBE = 8'h0c;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

  // ----------------------------------------------------------------------
  // widths, field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          CODE_W    = 12;
  localparam int          VALUE_W   = 16;
  localparam int          CTRL_W    = 8;
  localparam int          STAT_W    = 2;
  localparam int          SIGN_BIT  = 11;
  localparam logic [11:0] OFFSET_FLIP = 12'h800;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [11:0] CODE_RST  = 12'h000;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [1:0]  STAT_RST  = 2'h0;
  localparam logic [1:0]  IEN_RST   = 2'h0;

  // control register, bit 0 first from the bottom
  typedef struct packed {
    logic       twos_complement;           // bit 7
    logic [2:0] service_mode_bits;         // bits 6:4
    logic       dma_request_enable;        // bit 3
    logic       interrupt_request_enable;  // bit 2
    logic       internal_trigger_select;   // bit 1
    logic       waveform_update_enable;    // bit 0
  } dacu_ctrl_t;

  // status and enable registers share this layout; a clear write clears both flags unless a trigger edge lands in the same cycle
  typedef struct packed {
    logic update_overrun_error;            // bit 1
    logic update_done_flag;                // bit 0
  } dacu_stat_t;

  // apb slave phase
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC  = 2'b10
  } dacu_state_t;

endpackage : dacu_pkg

// ### dacu_top.sv
// Purpose: update control for two 12-bit analog output channels
// Assumes: one clock pclk at 10 MHz, presetn async active low, inputs synchronous
// Notes:   apb slave answers with one access cycle; see list below
//
// Summary of operation
// - each channel keeps its own 12-bit code, loaded from its value register
// - outputs update on value write in immediate mode, trigger pulse or strobe register write
// - in waveform mode a trigger falling edge updates both channels, sets done
// - trigger comes from internal bus if selected, else from external pin
// - interrupt enable with nonzero mode bits raises irq while a flag enabled in the enable register is set
// - dma enable with nonzero mode bits raises dma request while done set
// - dma acknowledge clears the done flag without a software write
// - trigger edge while done is still set raises the overrun flag
// - clear register write also clears the overrun flag
// - a control bit picks straight binary or two's complement codes
// - unipolar binary codes 0 to 4095 pass to the converter unchanged
// - bipolar binary codes 0 to 4095 pass unchanged, 2048 is zero
// - two's complement codes -2048..2047 come sign-extended in 16 bits

`timescale 1ns/1ps

module dacu_top
  import dacu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internal_trigger_n,
  input  wire logic        external_update_n,
  input  wire logic        dma_ack,
  output logic [11:0]      chan_a_code,
  output logic [11:0]      chan_b_code,
  output logic             dma_req,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  dacu_state_t       state_q, state_d;
  logic [15:0]       val_a_q, val_b_q;
  dacu_ctrl_t        ctrl_q;
  dacu_stat_t        stat_q, stat_d;
  dacu_stat_t        ien_q;
  logic [11:0]       code_a_q, code_b_q;
  logic              trig_prev_q;
  logic [31:0]       prdata_q;
  logic              pready_q, pslverr_q;
  logic              irq_q, dma_q;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  // access completes on the edge where our own pready_q is high
  wire setup_ph  = psel & ~penable;
  wire done_acc  = psel & penable & pready_q;
  wire wr_acc    = done_acc & pwrite;
  wire wr_cha    = wr_acc & (paddr == ADDR_CHA_VALUE);
  wire wr_chb    = wr_acc & (paddr == ADDR_CHB_VALUE);
  wire wr_ctrl   = wr_acc & (paddr == ADDR_CONTROL);
  wire wr_strobe = wr_acc & (paddr == ADDR_UPD_STROBE);
  wire wr_clear  = wr_acc & (paddr == ADDR_IRQ_CLEAR);
  wire wr_ien    = wr_acc & (paddr == ADDR_IRQ_ENABLE);
  wire mapped    = (paddr == ADDR_CHA_VALUE)  | (paddr == ADDR_CHB_VALUE) |
                   (paddr == ADDR_CONTROL)    | (paddr == ADDR_UPD_STROBE) |
                   (paddr == ADDR_STATUS)     | (paddr == ADDR_IRQ_CLEAR) |
                   (paddr == ADDR_IRQ_ENABLE);

  // status read has no side effect, so flags survive polling
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ADDR_CHA_VALUE:  rd_mux = {16'h0000, val_a_q};
      ADDR_CHB_VALUE:  rd_mux = {16'h0000, val_b_q};
      ADDR_CONTROL:    rd_mux = {24'h00_0000, ctrl_q};
      ADDR_STATUS:     rd_mux = {30'h0000_0000, stat_q};
      ADDR_IRQ_ENABLE: rd_mux = {30'h0000_0000, ien_q};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // phase tracking: one access cycle for every transfer
  always_comb begin
    case (state_q)
      ST_IDLE: state_d = setup_ph ? ST_ACC : ST_IDLE;
      ST_ACC:  state_d = setup_ph ? ST_ACC : ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // answer, error and read word are registered, so each stands one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      state_q   <= state_d;
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~mapped;
      prdata_q  <= (setup_ph & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // trigger selection and edge detect
  // ----------------------------------------------------------------------
  // switching the source while the chosen line is low looks like an edge;
  // software should change the source with waveform mode off
  wire trig_n    = ctrl_q.internal_trigger_select ?
                   internal_trigger_n : external_update_n;
  wire trig_fall = trig_prev_q & ~trig_n;
  wire trig_fire = trig_fall & ctrl_q.waveform_update_enable;

  // ----------------------------------------------------------------------
  // code conversion and update selection
  // ----------------------------------------------------------------------
  // upper sign-extension bits are dropped; only bit 11 carries the offset
  wire [11:0] flip   = ctrl_q.twos_complement ? OFFSET_FLIP : CODE_RST;
  wire [11:0] conv_a = val_a_q[CODE_W-1:0] ^ flip;
  wire [11:0] conv_b = val_b_q[CODE_W-1:0] ^ flip;
  wire [11:0] new_a  = pwdata[CODE_W-1:0] ^ flip;
  wire [11:0] new_b  = pwdata[CODE_W-1:0] ^ flip;
  wire        immed  = ~ctrl_q.waveform_update_enable;
  wire        upd_a  = wr_cha & immed;
  wire        upd_b  = wr_chb & immed;
  wire        upd_all = wr_strobe | trig_fire;

  // binary codes go straight through in either analog range
  wire [11:0] code_a_d = upd_a ? new_a : (upd_all ? conv_a : code_a_q);
  wire [11:0] code_b_d = upd_b ? new_b : (upd_all ? conv_b : code_b_q);

  // ----------------------------------------------------------------------
  // flags: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------------
  // mode bits of zero leave both service paths off
  wire dma_mode = ctrl_q.dma_request_enable & (|ctrl_q.service_mode_bits);
  wire int_mode = ctrl_q.interrupt_request_enable &
                  (|ctrl_q.service_mode_bits);
  wire ack_clr  = dma_ack & dma_q;

  always_comb begin
    stat_d = stat_q;
    if (wr_clear) begin
      stat_d.update_done_flag     = 1'b0;
      stat_d.update_overrun_error = 1'b0;
    end
    if (ack_clr) begin
      stat_d.update_done_flag = 1'b0;
    end
    if (trig_fire) begin
      stat_d.update_done_flag = 1'b1;
      if (stat_q.update_done_flag) begin
        stat_d.update_overrun_error = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // value registers and control settings written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_a_q <= VALUE_RST;
      val_b_q <= VALUE_RST;
      ctrl_q  <= CTRL_RST;
      ien_q   <= IEN_RST;
    end else begin
      if (wr_cha)  val_a_q <= pwdata[VALUE_W-1:0];
      if (wr_chb)  val_b_q <= pwdata[VALUE_W-1:0];
      if (wr_ctrl) ctrl_q  <= pwdata[CTRL_W-1:0];
      if (wr_ien)  ien_q   <= pwdata[STAT_W-1:0];
    end
  end

  // converter codes, flags and request lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_a_q    <= CODE_RST;
      code_b_q    <= CODE_RST;
      stat_q      <= STAT_RST;
      trig_prev_q <= 1'b1;
      irq_q       <= 1'b0;
      dma_q       <= 1'b0;
    end else begin
      code_a_q    <= code_a_d;
      code_b_q    <= code_b_d;
      stat_q      <= stat_d;
      trig_prev_q <= trig_n;
      irq_q       <= int_mode & (|(stat_d & ien_q));
      dma_q       <= dma_mode & stat_d.update_done_flag;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign chan_a_code = code_a_q;
  assign chan_b_code = code_b_q;
  assign irq         = irq_q;
  assign dma_req     = dma_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  cha_load_a: assert property (wr_cha && immed |=>
    chan_a_code == ($past(pwdata[CODE_W-1:0]) ^
    ($past(ctrl_q.twos_complement) ? OFFSET_FLIP : CODE_RST)))
    else $error("channel a code not loaded on immediate write");

  wave_hold_a: assert property (
    wr_chb && !immed && !upd_all |=> $stable(chan_b_code))
    else $error("channel b changed on write in waveform mode");

  trig_both_a: assert property (trig_fire && !wr_cha && !wr_chb |=>
    chan_a_code == $past(conv_a) && chan_b_code == $past(conv_b) &&
    stat_q.update_done_flag)
    else $error("trigger edge did not update both channels");

  ext_src_a: assert property (
    ctrl_q.waveform_update_enable && !ctrl_q.internal_trigger_select &&
    $fell(external_update_n) && $stable(ctrl_q) |=> stat_q.update_done_flag)
    else $error("external update pin edge missed");

  irq_level_a: assert property (
    int_mode && $stable(ctrl_q) && $stable(ien_q) &&
    (|(stat_q & ien_q)) |-> ##[0:1] irq)
    else $error("interrupt not raised for enabled flag");

  clear_flags_a: assert property (wr_clear && !trig_fire |=>
    !stat_q.update_done_flag && !stat_q.update_overrun_error && !irq)
    else $error("clear write left a flag or interrupt set");

  dma_req_a: assert property (
    dma_mode && stat_q.update_done_flag && !wr_clear |-> ##[0:1] dma_req)
    else $error("dma request missing while done set");

  dma_ack_a: assert property (dma_ack && dma_req && !trig_fire |=>
    !stat_q.update_done_flag)
    else $error("dma acknowledge did not clear done flag");

  overrun_set_a: assert property (
    trig_fire && stat_q.update_done_flag |=> stat_q.update_overrun_error)
    else $error("overrun not flagged");

  twos_map_a: assert property (
    wr_cha && immed && ctrl_q.twos_complement |=>
    chan_a_code[SIGN_BIT] == !$past(pwdata[SIGN_BIT]))
    else $error("two's complement bit 11 not inverted");

  sticky_flag_a: assert property (
    stat_q.update_done_flag && !wr_clear && !ack_clr |=>
    stat_q.update_done_flag)
    else $error("done flag dropped without a clear");

  // ----------------------------------------------------------------------
  // bus and mode checks
  // ----------------------------------------------------------------------
  // pready only ever stands in the access phase, and for one cycle
  apb_phase_a: assert property (pready |-> state_q == ST_ACC)
    else $error("pready outside the access phase");

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");

  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  // idle read bus is kept at zero so a stale word is never taken for data
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data driven outside an access");

  chb_load_a: assert property (wr_chb && immed |=>
    chan_b_code == ($past(pwdata[CODE_W-1:0]) ^
    ($past(ctrl_q.twos_complement) ? OFFSET_FLIP : CODE_RST)))
    else $error("channel b code not loaded on immediate write");

  strobe_both_a: assert property (wr_strobe |=>
    chan_a_code == $past(conv_a) && chan_b_code == $past(conv_b))
    else $error("strobe write did not update both channels");

  wave_off_a: assert property (
    trig_fall && !ctrl_q.waveform_update_enable && !stat_q.update_done_flag |=>
    !stat_q.update_done_flag)
    else $error("trigger edge acted with waveform mode off");

  int_src_a: assert property (
    ctrl_q.waveform_update_enable && ctrl_q.internal_trigger_select &&
    $fell(internal_trigger_n) && $stable(ctrl_q) |=> stat_q.update_done_flag)
    else $error("internal trigger edge missed");

  no_mode_irq_a: assert property (!int_mode |=> !irq)
    else $error("interrupt raised with interrupts not selected");

  no_mode_dma_a: assert property (!dma_mode |=> !dma_req)
    else $error("dma request raised with dma not selected");

  stat_ro_a: assert property (
    wr_acc && (paddr == ADDR_STATUS) && !trig_fire && !ack_clr |=> $stable(stat_q))
    else $error("status write changed a flag");

  ovr_sticky_a: assert property (
    stat_q.update_overrun_error && !wr_clear |=> stat_q.update_overrun_error)
    else $error("overrun flag dropped without a clear");

  ovr_cause_a: assert property (
    $rose(stat_q.update_overrun_error) |->
    $past(trig_fire) && $past(stat_q.update_done_flag))
    else $error("overrun flag set without a trigger on a set done flag");

  // straight binary codes reach the converter bit for bit
  bin_pass_a: assert property (
    wr_cha && immed && !ctrl_q.twos_complement |=>
    chan_a_code == $past(pwdata[CODE_W-1:0]))
    else $error("binary code altered on its way to the converter");

  code_hold_a: assert property (!upd_a && !upd_all |=> $stable(chan_a_code))
    else $error("channel a code changed with no update");

  // serviced update, overrun, dma handshake, bus error, internal source
  trig_cov: cover property (trig_fire ##[1:20] wr_clear);
  ovr_cov: cover property (trig_fire ##[1:50] trig_fire && stat_q.update_done_flag);
  dma_cov: cover property (dma_req ##[0:5] dma_ack);
  err_cov: cover property (done_acc && pslverr);
  src_cov: cover property (ctrl_q.internal_trigger_select && trig_fire);

endmodule : dacu_top

// ### dacu_dma_model.sv
// Purpose: dma controller stand-in that answers update requests
// Assumes: the request is a level that stays up until acknowledged
// Notes:   the bench holds ack_en low to stall, ack_delay sets the pace

`timescale 1ns/1ps

module dacu_dma_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       dma_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_delay,
  output logic            dma_ack
);
  // ----------------------------------------------------------------------
  // acknowledge sequencer
  // ----------------------------------------------------------------------
  logic [3:0] wait_q;

  // one-cycle ack to a standing request only, so a stale ack never meets a later flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q  <= 4'h0;
      dma_ack <= 1'b0;
    end else begin
      dma_ack <= 1'b0;
      if (!dma_req || dma_ack) begin
        wait_q <= 4'h0;
      end else if (ack_en && wait_q >= ack_delay) begin
        dma_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : dacu_dma_model

// ### testbench.sv
// Purpose: self-checking bench for the analog output update control
// Assumes: apb answers within a bounded wait, triggers are synchronous
// Notes:   codes are sampled on the falling edge, after updates land

`timescale 1ns/1ps

module testbench
  import dacu_pkg::*;
;
  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        internal_trigger_n = 1'b1;
  logic        external_update_n = 1'b1;
  logic        dma_ack;
  logic [11:0] chan_a_code;
  logic [11:0] chan_b_code;
  logic        dma_req;
  logic        irq;
  logic        ack_en = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;

  dacu_top i_dacu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_trigger_n(internal_trigger_n),
    .external_update_n(external_update_n), .dma_ack(dma_ack), .chan_a_code(chan_a_code),
    .chan_b_code(chan_b_code), .dma_req(dma_req), .irq(irq));

  dacu_dma_model i_dacu_dma_model (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
    .ack_en(ack_en), .ack_delay(4'h2), .dma_ack(dma_ack));

  // 10 MHz clock; the watchdog bounds the whole run
  always #50 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic conclude();
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdv(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdv

  task automatic codes(input logic [11:0] ea, input logic [11:0] eb);
    repeat (2) @(negedge pclk);
    chk("chan_a_code", {20'h0, ea}, {20'h0, chan_a_code});
    chk("chan_b_code", {20'h0, eb}, {20'h0, chan_b_code});
  endtask : codes

  // one low cycle on the chosen trigger source
  task automatic pulse(input logic internal);
    @(posedge pclk);
    if (internal) internal_trigger_n <= 1'b0;
    else external_update_n <= 1'b0;
    @(posedge pclk);
    internal_trigger_n <= 1'b1;
    external_update_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    codes(12'h000, 12'h000);
    rdv(ADDR_CONTROL, 32'h0, "control");
    rdv(ADDR_IRQ_ENABLE, 32'h0, "irq_enable");
    // immediate mode, upper value bits dropped, status is read-only
    apb(1'b1, ADDR_CHA_VALUE, 32'hffff_0fff);
    codes(12'hfff, 12'h000);
    apb(1'b1, ADDR_CHB_VALUE, 32'h0000_0800);
    codes(12'hfff, 12'h800);
    rdv(ADDR_CHA_VALUE, 32'h0000_0fff, "cha_value");
    apb(1'b1, ADDR_STATUS, 32'h3);
    rdv(ADDR_STATUS, 32'h0, "status");
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    // two's complement codes flip the sign bit
    apb(1'b1, ADDR_CONTROL, 32'h80);
    apb(1'b1, ADDR_CHA_VALUE, 32'h0000_f800);
    codes(12'h000, 12'h800);
    apb(1'b1, ADDR_CHB_VALUE, 32'h0000_ffff);
    codes(12'h000, 12'h7ff);
    // interrupt servicing: enables first, then waveform mode
    apb(1'b1, ADDR_CONTROL, 32'h14);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h3);
    apb(1'b1, ADDR_CONTROL, 32'h15);
    apb(1'b1, ADDR_CHA_VALUE, 32'h0123);
    apb(1'b1, ADDR_CHB_VALUE, 32'h0456);
    codes(12'h000, 12'h7ff);
    pulse(1'b0);
    codes(12'h123, 12'h456);
    rdv(ADDR_STATUS, 32'h1, "status");
    rdv(ADDR_STATUS, 32'h1, "status");
    chk("irq", 32'h1, {31'h0, irq});
    pulse(1'b0);
    rdv(ADDR_STATUS, 32'h3, "status");
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h0);
    rdv(ADDR_STATUS, 32'h0, "status");
    chk("irq", 32'h0, {31'h0, irq});
    // masked done bit keeps irq low until the overrun bit fires
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h2);
    pulse(1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    pulse(1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h0);
    // internal source selected: the external pin is ignored
    apb(1'b1, ADDR_CONTROL, 32'h17);
    apb(1'b1, ADDR_CHA_VALUE, 32'h0aaa);
    pulse(1'b0);
    codes(12'h123, 12'h456);
    pulse(1'b1);
    codes(12'haaa, 12'h456);
    rdv(ADDR_STATUS, 32'h1, "status");
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h0);
    // strobe updates without flags; trigger ignored with waveform off
    apb(1'b1, ADDR_CHB_VALUE, 32'h0321);
    apb(1'b1, ADDR_UPD_STROBE, 32'h0);
    codes(12'haaa, 12'h321);
    apb(1'b1, ADDR_CONTROL, 32'h16);
    pulse(1'b1);
    rdv(ADDR_STATUS, 32'h0, "status");
    // interrupt enable with no mode bits raises nothing
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h3);
    apb(1'b1, ADDR_CONTROL, 32'h05);
    pulse(1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    rdv(ADDR_STATUS, 32'h1, "status");
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h0);
    // dma servicing, controller stalled first, then answering
    apb(1'b1, ADDR_CONTROL, 32'h18);
    apb(1'b1, ADDR_CONTROL, 32'h19);
    pulse(1'b0);
    chk("dma_req", 32'h1, {31'h0, dma_req});
    rdv(ADDR_STATUS, 32'h1, "status");
    ack_en <= 1'b1;
    repeat (12) @(posedge pclk);
    chk("dma_req", 32'h0, {31'h0, dma_req});
    rdv(ADDR_STATUS, 32'h0, "status");
    // reset in mid-run returns codes, requests and settings to zero
    presetn <= 1'b0;
    codes(12'h000, 12'h000);
    chk("irq", 32'h0, {31'h0, irq});
    chk("dma_req", 32'h0, {31'h0, dma_req});
    @(posedge pclk);
    presetn <= 1'b1;
    rdv(ADDR_CONTROL, 32'h0, "control");
    rdv(ADDR_STATUS, 32'h0, "status");
    conclude();
  end
endmodule : testbench
